// File: design/csf_pkg.sv
// Constants and carrier types for the carousel section framer.
// Assumes a single 100 MHz clock domain shared by all users of this package.
// Functional notes
// - Carousel sections leave the block wrapped in UDP over IPv4 datagrams that carry the carousel header.
// - The carousel header sits at the very first byte of the UDP payload in every datagram.
// - The header is followed directly by exactly one complete section, one of each per datagram.
// - No IP fragmentation is used; a section whose datagram would reach or exceed the MTU is not emitted.
// - The header opens with a 2-bit version of 0x1 and then a reserved bit driven to 0x1.
// - After the reserved bit comes the 13-bit transport stream PID of the section, most significant bit first.
// - No transport stream packetization is added; the PID travels only in the header field.
package csf_pkg;
   localparam logic [1:0] CSF_VERSION = 2'h1;
   localparam logic CSF_RESERVED = 1'h1;
   localparam logic [7:0] CSF_IP_VER_IHL = 8'h45;
   localparam logic [7:0] CSF_IP_TOS = 8'h00;
   localparam logic [15:0] CSF_IP_FLAGS_DF = 16'h4000;
   localparam logic [7:0] CSF_IP_PROTO_UDP = 8'h11;
   localparam logic [15:0] CSF_UDP_HDR_BYTES = 16'h000A;
   localparam logic [15:0] CSF_HDR_BYTES = 16'h001E;
   localparam logic [4:0] CSF_HDR_LAST = 5'h1D;
   localparam logic [15:0] CSF_CAR_HDR_IDX = 16'h001C;
   localparam logic [15:0] CSF_IP_FLAGS_IDX = 16'h0006;
   localparam logic [15:0] CSF_IP_PROTO_IDX = 16'h0009;
   localparam logic [15:0] CSF_IP_ID_RESET = 16'h0000;
   localparam logic [15:0] CSF_DEFAULT_MTU = 16'h05DC;

   typedef enum logic [1:0] {
      CSF_IDLE = 2'b00,
      CSF_HDR = 2'b01,
      CSF_PAY = 2'b10,
      CSF_DROP = 2'b11
   } csf_state_t;

   typedef struct packed {
      logic [31:0] src_ip;
      logic [31:0] dst_ip;
      logic [15:0] src_port;
      logic [15:0] dst_port;
      logic [7:0] ttl;
   } csf_cfg_t;

   typedef struct packed {
      logic [12:0] pid;
      logic [12:0] len;
   } csf_req_t;
endpackage : csf_pkg

// File: design/csf_framer.sv
// Carousel section framer: builds IPv4/UDP datagrams, one carousel header and one section each.
// Assumes section bytes arrive in order after their request, and the sink honours out_ready.
`timescale 1ns/1ns
module csf_framer
   import csf_pkg::*;
#(
   parameter logic [15:0] MTU = CSF_DEFAULT_MTU
) (
   input wire logic clk,
   input wire logic resetn,
   input wire csf_cfg_t cfg,
   input wire logic req_valid,
   input wire csf_req_t req,
   output logic req_ready,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_first,
   output logic out_last,
   input wire logic out_ready,
   output logic drop
);

   function automatic logic [15:0] ip_csum(input logic [159:0] h);
      logic [19:0] s;
      s = 20'h00000;
      for (int i = 0; i < 10; i++) begin
         s = s + {4'h0, h[i*16 +: 16]};
      end
      s = {4'h0, s[15:0]} + {16'h0000, s[19:16]};
      s = {4'h0, s[15:0]} + {16'h0000, s[19:16]};
      return ~s[15:0];
   endfunction : ip_csum

   csf_state_t state_reg;
   logic [239:0] hdr_reg;
   logic [4:0] hdr_cnt_reg;
   logic [12:0] rem_reg;
   logic [12:0] len_reg;
   logic [12:0] pid_reg;
   logic [15:0] ip_id_reg;
   logic [15:0] out_idx_reg;
   logic req_ready_reg, in_ready_reg, drop_reg;
   logic out_valid_reg, out_first_reg, out_last_reg;
   logic [7:0] out_data_reg;

   logic req_fire, in_fire, slot_free, hdr_load, too_big;
   logic [15:0] ip_total, udp_len;
   logic [159:0] ip_nock;

   assign req_fire = req_valid && req_ready_reg;
   assign in_fire = in_valid && in_ready_reg;
   assign slot_free = !out_valid_reg || out_ready;
   assign hdr_load = (state_reg == CSF_HDR) && slot_free;
   assign ip_total = {3'h0, req.len} + CSF_HDR_BYTES;
   assign udp_len = {3'h0, req.len} + CSF_UDP_HDR_BYTES;
   assign too_big = (ip_total >= MTU) || (req.len == 13'h0000);
   assign ip_nock = {CSF_IP_VER_IHL, CSF_IP_TOS, ip_total, ip_id_reg, CSF_IP_FLAGS_DF,
                     cfg.ttl, CSF_IP_PROTO_UDP, 16'h0000, cfg.src_ip, cfg.dst_ip};

   // Sequencing of one request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= CSF_IDLE;
         rem_reg <= 13'h0000;
         hdr_cnt_reg <= 5'h00;
      end else begin
         unique case (state_reg)
            CSF_IDLE: begin
               if (req_fire) begin
                  rem_reg <= req.len;
                  hdr_cnt_reg <= 5'h00;
                  if (req.len == 13'h0000) begin
                     state_reg <= CSF_IDLE;
                  end else if (too_big) begin
                     state_reg <= CSF_DROP;
                  end else begin
                     state_reg <= CSF_HDR;
                  end
               end
            end
            CSF_HDR: begin
               if (hdr_load) begin
                  hdr_cnt_reg <= hdr_cnt_reg + 5'h01;
                  if (hdr_cnt_reg == CSF_HDR_LAST) begin
                     state_reg <= CSF_PAY;
                  end
               end
            end
            CSF_PAY, CSF_DROP: begin
               if (in_fire) begin
                  rem_reg <= rem_reg - 13'h0001;
                  if (rem_reg == 13'h0001) begin
                     state_reg <= CSF_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Header image captured at request time, shifted out most significant byte first
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hdr_reg <= 240'h0;
         len_reg <= 13'h0000;
         pid_reg <= 13'h0000;
      end else if (req_fire) begin
         len_reg <= req.len;
         pid_reg <= req.pid;
         hdr_reg <= {ip_nock[159:80], ip_csum(ip_nock), ip_nock[63:0],
                     cfg.src_port, cfg.dst_port, udp_len, 16'h0000,
                     CSF_VERSION, CSF_RESERVED, req.pid};
      end else if (hdr_load) begin
         hdr_reg <= {hdr_reg[231:0], 8'h00};
      end
   end

   // Datagram identification advances once per emitted datagram
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ip_id_reg <= CSF_IP_ID_RESET;
      end else if (req_fire && !too_big) begin
         ip_id_reg <= ip_id_reg + 16'h0001;
      end
   end

   // Handshake flops toward the sources; in_ready rises onto an empty output slot in CSF_PAY, and without waiting for one in CSF_DROP
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_ready_reg <= 1'b0;
         in_ready_reg <= 1'b0;
         drop_reg <= 1'b0;
      end else begin
         req_ready_reg <= (state_reg == CSF_IDLE) && !req_fire;
         drop_reg <= req_fire && too_big;
         if (in_fire) begin
            in_ready_reg <= 1'b0;
         end else if (state_reg == CSF_DROP) begin
            in_ready_reg <= 1'b1;
         end else if (state_reg == CSF_PAY && slot_free) begin
            in_ready_reg <= 1'b1;
         end
      end
   end

   // Output byte register; section bytes pass unchanged
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_valid_reg <= 1'b0;
         out_data_reg <= 8'h00;
         out_first_reg <= 1'b0;
         out_last_reg <= 1'b0;
         out_idx_reg <= 16'h0000;
      end else if (hdr_load) begin
         out_valid_reg <= 1'b1;
         out_data_reg <= hdr_reg[239:232];
         out_first_reg <= (hdr_cnt_reg == 5'h00);
         out_last_reg <= 1'b0;
         out_idx_reg <= {11'h000, hdr_cnt_reg};
      end else if (state_reg == CSF_PAY && in_fire) begin
         out_valid_reg <= 1'b1;
         out_data_reg <= in_data;
         out_first_reg <= 1'b0;
         out_last_reg <= (rem_reg == 13'h0001);
         out_idx_reg <= CSF_HDR_BYTES + {3'h0, len_reg} - {3'h0, rem_reg};
      end else if (out_ready) begin
         out_valid_reg <= 1'b0;
      end
   end

   assign req_ready = req_ready_reg;
   assign in_ready = in_ready_reg;
   assign out_valid = out_valid_reg;
   assign out_data = out_data_reg;
   assign out_first = out_first_reg;
   assign out_last = out_last_reg;
   assign drop = drop_reg;

   sequence s_take_byte;
      state_reg == CSF_PAY && in_fire;
   endsequence

   property p_first_ipv4;
      @(posedge clk) disable iff (!resetn)
         out_valid_reg && out_first_reg |-> out_data_reg == CSF_IP_VER_IHL;
   endproperty
   a_first_ipv4: assert property (p_first_ipv4) else $error("datagram not IPv4");

   property p_proto_udp;
      @(posedge clk) disable iff (!resetn)
         out_valid_reg && out_idx_reg == CSF_IP_PROTO_IDX |-> out_data_reg == CSF_IP_PROTO_UDP;
   endproperty
   a_proto_udp: assert property (p_proto_udp) else $error("protocol not UDP");

   property p_car_hdr_hi;
      @(posedge clk) disable iff (!resetn)
         out_valid_reg && out_idx_reg == CSF_CAR_HDR_IDX |->
            out_data_reg == {CSF_VERSION, CSF_RESERVED, pid_reg[12:8]};
   endproperty
   a_car_hdr_hi: assert property (p_car_hdr_hi) else $error("bad first header byte");

   property p_car_hdr_lo;
      @(posedge clk) disable iff (!resetn)
         out_valid_reg && out_idx_reg == CSF_CAR_HDR_IDX + 16'h0001 |->
            out_data_reg == pid_reg[7:0];
   endproperty
   a_car_hdr_lo: assert property (p_car_hdr_lo) else $error("bad PID low byte");

   property p_no_frag;
      @(posedge clk) disable iff (!resetn)
         out_valid_reg && out_idx_reg == CSF_IP_FLAGS_IDX |-> out_data_reg[6];
   endproperty
   a_no_frag: assert property (p_no_frag) else $error("dont-fragment bit clear");

   property p_oversize_drop;
      @(posedge clk) disable iff (!resetn)
         req_fire && too_big |=> state_reg != CSF_HDR && drop_reg;
   endproperty
   a_oversize_drop: assert property (p_oversize_drop) else $error("oversize section framed");

   property p_last_pos;
      @(posedge clk) disable iff (!resetn)
         out_valid_reg && out_last_reg |->
            out_idx_reg == CSF_HDR_BYTES + {3'h0, len_reg} - 16'h0001;
   endproperty
   a_last_pos: assert property (p_last_pos) else $error("section end misplaced");

   property p_pass_through;
      logic [7:0] d;
      @(posedge clk) disable iff (!resetn)
         (s_take_byte, d = in_data) |=> out_valid_reg && out_data_reg == d;
   endproperty
   a_pass_through: assert property (p_pass_through) else $error("section byte altered");

   property p_hold;
      @(posedge clk) disable iff (!resetn)
         out_valid_reg && !out_ready |=> out_valid_reg && $stable(out_data_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("output changed under stall");

endmodule : csf_framer

// File: sim/csf_sink_model.sv
// Sink model: the client end that takes all datagram bytes and counts datagrams whose header PID matches want_pid.
// Assumes one clock; the bench reads the captured queue and may ask for stalls.
`timescale 1ns/1ns
module csf_sink_model
   import csf_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic stall,
   input wire logic [12:0] want_pid,
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   input wire logic out_first,
   input wire logic out_last,
   output logic out_ready
);
   logic [9:0] got[$];
   logic [7:0] hdr_reg;
   logic [1:0] cnt_reg;
   int hits = 0;
   int idx = 0;
   // Stalling takes one byte in four
   assign out_ready = !stall || cnt_reg == 2'h0;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 2'h0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end
   // Position of the previously taken byte is kept in idx
   always @(posedge clk) begin
      if (resetn && out_valid && out_ready) begin
         idx <= out_first ? 0 : idx + 1;
         got.push_back({out_last, out_first, out_data});
         if (!out_first && idx == 27) begin
            hdr_reg <= out_data;
         end
         if (!out_first && idx == 28 && {hdr_reg[4:0], out_data} == want_pid) begin
            hits <= hits + 1;
         end
      end
   end
endmodule : csf_sink_model

// File: sim/test_carousel_section_framer.sv
// Testbench for the carousel section framer with a small MTU.
// Assumes the sink model stands on the datagram side.
`timescale 1ns/1ns
module test_carousel_section_framer;
   import csf_pkg::*;
   localparam logic [15:0] SIM_MTU = 16'h0040;
   localparam logic [12:0] WANT_PID = 13'h1ABC;
   logic clk, resetn, req_valid, req_ready, in_valid, in_ready, stall;
   logic out_valid, out_first, out_last, out_ready, drop;
   logic [7:0] in_data, out_data;
   csf_cfg_t cfg;
   csf_req_t req;
   int num_errors = 0;
   int checks_done = 0;
   int drops = 0;
   csf_framer #(.MTU(SIM_MTU)) dut_u (.clk(clk), .resetn(resetn), .cfg(cfg),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .in_valid(in_valid),
      .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
      .out_first(out_first), .out_last(out_last), .out_ready(out_ready), .drop(drop));
   csf_sink_model sink_u (.clk(clk), .resetn(resetn), .stall(stall), .want_pid(WANT_PID),
      .out_valid(out_valid), .out_data(out_data), .out_first(out_first),
      .out_last(out_last), .out_ready(out_ready));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (drop === 1'b1) begin
         drops <= drops + 1;
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic guard(input int n);
      if (n > 400) begin
         num_errors++;
         wrap_up();
      end
   endtask : guard
   function automatic logic [15:0] gb(input int k);
      return {sink_u.got[k][7:0], sink_u.got[k+1][7:0]};
   endfunction : gb
   task automatic send(input logic [12:0] pid, input int len);
      int n;
      req_valid = 1'b1;
      req = '{pid: pid, len: len[12:0]};
      n = 0;
      while (req_ready !== 1'b1) begin
         step();
         n++;
         guard(n);
      end
      step();
      req_valid = 1'b0;
      for (int i = 0; i < len; i++) begin
         in_valid = 1'b1;
         in_data = 8'(i + 3);
         n = 0;
         while (in_ready !== 1'b1) begin
            step();
            n++;
            guard(n);
         end
         step();
      end
      in_valid = 1'b0;
   endtask : send
   task automatic frame_test(input logic [12:0] pid, input int len, input logic [15:0] id,
      input logic stl);
      int n;
      int tot;
      int sum;
      int h;
      tot = 30 + len;
      stall = stl;
      h = sink_u.hits;
      sink_u.got.delete();
      send(pid, len);
      n = 0;
      while (sink_u.got.size() < tot) begin
         step();
         n++;
         guard(n);
      end
      repeat (40) step();
      check(16'(sink_u.got.size()), 16'(tot));
      check({6'h0, sink_u.got[0]}, 16'h0145);
      check({8'h00, sink_u.got[1][7:0]}, {8'h00, CSF_IP_TOS});
      check(gb(2), 16'(tot));
      check(gb(4), id);
      check(gb(6), CSF_IP_FLAGS_DF);
      check(gb(8), {cfg.ttl, CSF_IP_PROTO_UDP});
      check(gb(12), cfg.src_ip[31:16]);
      check(gb(14), cfg.src_ip[15:0]);
      check(gb(16), cfg.dst_ip[31:16]);
      check(gb(18), cfg.dst_ip[15:0]);
      check(gb(20), cfg.src_port);
      check(gb(22), cfg.dst_port);
      check(gb(24), 16'(len + 10));
      check(gb(26), 16'h0000);
      check(gb(28), {2'h1, 1'h1, pid});
      // Ones-complement sum over a valid IPv4 header, checksum included, is all ones
      sum = 0;
      for (int k = 0; k < 20; k += 2) begin
         sum = sum + int'(gb(k));
      end
      sum = (sum % 65536) + (sum / 65536);
      sum = (sum % 65536) + (sum / 65536);
      check(16'(sum), 16'hFFFF);
      for (int k = 1; k < 30; k++) begin
         check(16'(sink_u.got[k][9:8]), 16'h0000);
      end
      for (int i = 0; i < len; i++) begin
         check({6'h0, sink_u.got[30+i]}, {6'h0, i == len - 1, 1'b0, 8'(i + 3)});
      end
      check(16'(sink_u.hits - h), 16'(pid == WANT_PID));
      $display("frame pid %0h len %0d done", pid, len);
   endtask : frame_test
   task automatic refuse_test(input int len);
      int d;
      d = drops;
      sink_u.got.delete();
      send(13'h0055, len);
      repeat (40) step();
      check(16'(drops), 16'(d + 1));
      check(16'(sink_u.got.size()), 16'h0000);
      $display("refuse len %0d done", len);
   endtask : refuse_test
   initial begin
      resetn = 1'b0;
      req_valid = 1'b0;
      in_valid = 1'b0;
      req = '0;
      in_data = 8'h00;
      stall = 1'b0;
      cfg = '{src_ip: 32'h0A000001, dst_ip: 32'hEF000001, src_port: 16'h1000,
         dst_port: 16'h2000, ttl: 8'h40};
      repeat (20) @(posedge clk);
      #1 resetn = 1'b1;
      step();
      frame_test(13'h1ABC, 4, 16'h0000, 1'b1);
      frame_test(13'h0001, 33, 16'h0001, 1'b0);
      refuse_test(34);
      refuse_test(0);
      frame_test(13'h1FFF, 1, 16'h0002, 1'b1);
      wrap_up();
   end
endmodule : test_carousel_section_framer
